// >>> logic/daisy_chain_direction_forwarder.sv
`timescale 1ns/100ps
`include "chain_params.svh"

// How it works
// - Top mode: high side requests exit low link.
// - Bottom mode: low side requests exit high link.
// - Responding node drives both chain links.
// - Forward responses, turn links around automatically.
// - First wake-up side fixes request direction.
// - Host may wake through either host port.
// - Direction holds until the next wake-up.
// - Ring: returning request goes to host.
// - Ring: response reaches both host ports.
// - Bits pass unchanged between paired ports.
// - Fixed short bit delay, no frame storage.
// - Responder waits reply delay before answering.
// - Host port wake-up exits opposite chain link.
// - Idle host line stays at one.
// - One two-way pin per host port.
module daisy_chain_direction_forwarder
    import chain_pkg::*;
#(
    parameter int IDLE_CYC = `FWD_IDLE_CYC
)
(
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   sleep_req,
    chain_if.dev        link,
    output logic        awake,
    output topology_e   topology
);

    localparam int CW = $clog2(IDLE_CYC + 1);

    // ************************************************************
    // Path table
    // ************************************************************
    // Path 0 carries requests, paths 1 and 2 carry whatever comes
    // back from the chain. Each host port pairs with the chain link
    // of the opposite side.
    function automatic pin_e path_src
    (
        input path_t     p,
        input topology_e t
    );
        case (p)
            2'h0:
                path_src = (t == master_on_top) ? pin_high_host
                                                : pin_low_host;
            2'h1:
                path_src = pin_high_chain;
            default:
                path_src = pin_low_chain;
        endcase
    endfunction : path_src

    function automatic pin_e path_dst
    (
        input path_t     p,
        input topology_e t
    );
        case (p)
            2'h0:
                path_dst = (t == master_on_top) ? pin_low_chain
                                                : pin_high_chain;
            2'h1:
                path_dst = pin_low_host;
            default:
                path_dst = pin_high_host;
        endcase
    endfunction : path_dst

    // ************************************************************
    // Declarations
    // ************************************************************
    fwd_state_e         state;
    logic [2:0]         sync [`NUM_PINS];
    logic [3:0]         lvl;
    logic [2:0]         eng;
    logic [2:0]         next_eng;
    logic [CW-1:0]      idle_cnt [`NUM_PATHS];
    logic [3:0]         busy;
    logic [3:0]         out_o;
    logic [3:0]         out_oe;

    // Host pins are split into line, drive value and enable.
    assign link.dev_o  = out_o;
    assign link.dev_oe = out_oe;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Lines come from outside this clock. A level is accepted once
    // the second and third stages agree, which filters a single
    // metastable sample at the cost of one extra cycle of delay.
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < `NUM_PINS; i++)
        begin
            if (rst)
                sync[i] <= `SYNC_IDLE;
            else
                sync[i] <= {sync[i][1:0], link.line[i]};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            lvl <= `LINE_IDLE;
        else
        begin
            for (int i = 0; i < `NUM_PINS; i++)
            begin
                if (sync[i][1] == sync[i][2])
                    lvl[i] <= sync[i][2];
            end
        end
    end

    // ************************************************************
    // Wake-up and topology
    // ************************************************************
    // The first host port seen low while asleep fixes the request
    // direction; nothing but a new sleep and wake cycle changes it.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state    <= st_asleep;
            topology <= master_on_top;
        end
        else
        begin
            case (state)
                st_asleep:
                begin
                    if (!lvl[pin_high_host])
                    begin
                        topology <= master_on_top;
                        state    <= st_running;
                    end
                    else if (!lvl[pin_low_host])
                    begin
                        topology <= master_on_bottom;
                        state    <= st_running;
                    end
                end
                st_running:
                begin
                    if (sleep_req)
                        state <= st_asleep;
                end
                default:
                    state <= st_asleep;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            awake <= 1'b0;
        else
            awake <= (state == st_running);
    end

    // ************************************************************
    // Path engagement and turnaround
    // ************************************************************
    // A path takes a start bit on its source when neither of its
    // pins is held by another path. The request path is looked at
    // first, so a request never loses its link to an echo of
    // itself, and the return paths never drive a link that is
    // sending a request.
    always_comb
    begin
        pin_e s;
        pin_e d;
        s        = pin_high_host;
        d        = pin_high_host;
        next_eng = eng;
        busy     = 4'h0;
        for (int p = 0; p < `NUM_PATHS; p++)
        begin
            if (eng[p])
            begin
                busy[path_src(path_t'(p), topology)] = 1'b1;
                busy[path_dst(path_t'(p), topology)] = 1'b1;
            end
        end
        for (int p = 0; p < `NUM_PATHS; p++)
        begin
            s = path_src(path_t'(p), topology);
            d = path_dst(path_t'(p), topology);
            if (!eng[p])
            begin
                // Paths open only while running; a request only in the wake-up direction.
                if (state == st_running && !lvl[s] && !busy[s]
                    && !busy[d])
                begin
                    next_eng[p] = 1'b1;
                    busy[s]     = 1'b1;
                    busy[d]     = 1'b1;
                end
            end
            else if (state != st_running)
                next_eng[p] = 1'b0;
            else if (lvl[s] && idle_cnt[p] == CW'(IDLE_CYC - 1))
                next_eng[p] = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            eng <= 3'h0;
        else
            eng <= next_eng;
    end

    // Counts unbroken quiet on each engaged source.
    always_ff @(posedge mclk)
    begin
        for (int p = 0; p < `NUM_PATHS; p++)
        begin
            if (rst)
                idle_cnt[p] <= '0;
            else if (!eng[p] || !lvl[path_src(path_t'(p), topology)])
                idle_cnt[p] <= '0;
            else
                idle_cnt[p] <= idle_cnt[p] + 1'b1;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Each bit is copied as it arrives, five clocks after the pin,
    // and a frame is never held; in a ring the echo of a request
    // reaches the host while it is still sending. A link that no
    // path drives is released and listens.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            out_o  <= `LINE_IDLE;
            out_oe <= 4'h0;
        end
        else
        begin
            out_o  <= `LINE_IDLE;
            out_oe <= 4'h0;
            for (int p = 0; p < `NUM_PATHS; p++)
            begin
                if (eng[p])
                begin
                    // Request to the chain, wake-up included.
                    // Echo and replies back to the host.
                    out_oe[path_dst(path_t'(p), topology)] <= 1'b1;
                    out_o[path_dst(path_t'(p), topology)]  <=
                        lvl[path_src(path_t'(p), topology)];
                end
            end
        end
    end

endmodule : daisy_chain_direction_forwarder

// >>> logic/chain_params.svh
`ifndef CHAIN_PARAMS_SVH
`define CHAIN_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define MCLK_MHZ          200
// Quiet time on a source line after which a forwarding path is let go.
`define FWD_IDLE_NS       5000
`define FWD_IDLE_CYC      ((`FWD_IDLE_NS * `MCLK_MHZ + 999) / 1000)
// Least wait of a responder between request end and its reply.
`define REPLY_DELAY_NS    10000
`define REPLY_DELAY_CYC   ((`REPLY_DELAY_NS * `MCLK_MHZ + 999) / 1000)

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define NUM_PINS          4
`define NUM_PATHS         3
`define LINE_IDLE         4'hf
`define SYNC_IDLE         3'h7

`endif

// >>> logic/chain_pkg.sv
package chain_pkg;

    typedef enum logic
    {
        master_on_top,
        master_on_bottom
    } topology_e;

    typedef enum logic [1:0]
    {
        pin_high_host,
        pin_low_host,
        pin_high_chain,
        pin_low_chain
    } pin_e;

    typedef enum
    {
        st_asleep,
        st_running
    } fwd_state_e;

    typedef enum
    {
        st_idle,
        st_wait,
        st_reply
    } reply_state_e;

    typedef logic [1:0] path_t;

endpackage : chain_pkg

// >>> logic/chain_if.sv
`timescale 1ns/100ps

// ****************************************************************
// Four single-wire lines indexed by pin_e
// ****************************************************************
// Bit 0 high_host_port, 1 low_host_port, 2 high_side_chain_link,
// 3 low_side_chain_link. An undriven line idles high.
interface chain_if;
    logic [3:0] dev_o;
    logic [3:0] dev_oe;
    logic [3:0] far_o;
    logic [3:0] far_oe;
    logic [3:0] line;

    // The device end wins a clash so that contention shows up as a
    // corrupted far-end frame rather than an unknown level.
    assign line = (dev_oe & dev_o)
                | (~dev_oe & far_oe & far_o)
                | (~dev_oe & ~far_oe);

    modport dev
    (
        input  line,
        output dev_o,
        output dev_oe
    );

    modport far
    (
        input  line,
        output far_o,
        output far_oe
    );
endinterface : chain_if

// >>> logic/chain_far_end.sv
`timescale 1ns/100ps
`include "chain_params.svh"

module chain_far_end
    import chain_pkg::*;
#(
    parameter int REPLY_CYC = `REPLY_DELAY_CYC
)
(
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   host_high_en,
    input  wire logic   host_high_bit,
    input  wire logic   host_low_en,
    input  wire logic   host_low_bit,
    input  wire logic   reply_arm,
    input  wire logic   reply_en,
    input  wire logic   reply_bit,
    chain_if.far        link,
    output logic [3:0]  line_seen,
    output logic        replying
);

    localparam int CW = $clog2(REPLY_CYC + 1);

    reply_state_e   state;
    logic [CW-1:0]  quiet_cnt;
    logic [3:0]     out_o;
    logic [3:0]     out_oe;
    logic           chain_quiet;

    assign link.far_o  = out_o;
    assign link.far_oe = out_oe;
    assign chain_quiet = line_seen[pin_high_chain] & line_seen[pin_low_chain];

    always_ff @(posedge mclk)
    begin
        if (rst)
            line_seen <= `LINE_IDLE;
        else
            line_seen <= link.line;
    end

    // ************************************************************
    // Responder sequencing
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state     <= st_idle;
            quiet_cnt <= '0;
        end
        else
        begin
            case (state)
                st_idle:
                begin
                    quiet_cnt <= '0;
                    if (reply_arm)
                        state <= st_wait;
                end
                st_wait:
                begin
                    // Any chain activity restarts the wait.
                    if (!chain_quiet)
                        quiet_cnt <= '0;
                    else if (quiet_cnt == CW'(REPLY_CYC - 1))
                        state <= st_reply;
                    else
                        quiet_cnt <= quiet_cnt + 1'b1;
                end
                st_reply:
                begin
                    if (!reply_en)
                        state <= st_idle;
                end
                default:
                    state <= st_idle;
            endcase
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            out_o    <= `LINE_IDLE;
            out_oe   <= 4'h0;
            replying <= 1'b0;
        end
        else
        begin
            // Host lines sit at one when not sending.
            out_oe[pin_high_host] <= host_high_en;
            out_o[pin_high_host]  <= host_high_en ? host_high_bit : 1'b1;
            out_oe[pin_low_host]  <= host_low_en;
            out_o[pin_low_host]   <= host_low_en ? host_low_bit : 1'b1;
            // A reply leaves on both chain links at once.
            replying               <= (state == st_reply) && reply_en;
            out_oe[pin_high_chain] <= (state == st_reply) && reply_en;
            out_oe[pin_low_chain]  <= (state == st_reply) && reply_en;
            out_o[pin_high_chain]  <= reply_en ? reply_bit : 1'b1;
            out_o[pin_low_chain]   <= reply_en ? reply_bit : 1'b1;
        end
    end

endmodule : chain_far_end

// >>> verif/chain_fwd_sva.sv
`timescale 1ns/100ps

// ********
// Forwarding checks
// ********
module chain_fwd_sva
    import chain_pkg::*;
#(
    parameter int IDLE_CYC = 20
)
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] line,
    input wire logic       awake,
    input wire topology_e  topology
);
    int quiet [4];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Output pin k is fed by pin 3-k, so its quiet time is counted there.
    always_ff @(posedge mclk)
    begin
        for (int k = 0; k < 4; k++)
        begin
            quiet[k] <= (rst || !line[3 - k]) ? 0 : quiet[k] + 1;
        end
    end

    for (genvar k = 0; k < 4; k++)
    begin : g_pin
        chk_bit_follow: assert property (
            dev_oe[k] && $past(dev_oe[k], 5) |->
            dev_o[k] == $past(line[3 - k], 5) ||
            dev_o[k] == $past(line[3 - k], 6))
            else $error("forwarded bit differs from its source");
        chk_idle_release: assert property (
            dev_oe[k] |-> quiet[k] <= IDLE_CYC + 9)
            else $error("drive held too long after source went quiet");
        chk_no_early_drop: assert property (
            $fell(dev_oe[k]) |-> quiet[k] >= IDLE_CYC)
            else $error("drive dropped while source still active");
    end

    chk_top_route: assert property (
        awake && topology == master_on_top |-> !dev_oe[2])
        else $error("high chain link driven in top topology");
    chk_bottom_route: assert property (
        awake && topology == master_on_bottom |-> !dev_oe[3])
        else $error("low chain link driven in bottom topology");
    chk_asleep_quiet: assert property (
        !awake |-> !$rose(dev_oe[2]) && !$rose(dev_oe[3]))
        else $error("chain link driven while asleep");
    chk_topo_hold: assert property (
        awake && $past(awake) |-> $stable(topology))
        else $error("topology changed while awake");
    chk_one_way: assert property (
        !(dev_oe[0] && dev_oe[3]) && !(dev_oe[1] && dev_oe[2]))
        else $error("a port pair is driven both ways");
    chk_reply_same: assert property (
        dev_oe[0] && dev_oe[1] |-> dev_o[0] == dev_o[1])
        else $error("host ports carry different replies");

    cover property ($rose(awake) ##2 topology == master_on_bottom);
    cover property (dev_oe[0] && dev_oe[1]);
    cover property ($fell(dev_oe[3]));
    cover property (dev_oe[1] && dev_oe[3]);
endmodule : chain_fwd_sva

// >>> verif/daisy_chain_direction_forwarder_test.sv
`timescale 1ns/100ps

// ********
// Bench
// ********
module daisy_chain_direction_forwarder_test
    import chain_pkg::*;
;
    localparam int          IDLE  = 20;
    localparam int          REPLY = 30;
    localparam logic [9:0]  F1    = 10'h2ca;
    localparam logic [9:0]  F2    = 10'h35a;
    logic       mclk;
    logic       rst;
    logic       sleep_req;
    logic       awake;
    topology_e  topology;
    logic       host_high_en;
    logic       host_high_bit;
    logic       host_low_en;
    logic       host_low_bit;
    logic       reply_arm;
    logic       reply_en;
    logic       reply_bit;
    logic       replying;
    logic [3:0] line_seen;
    int         miscompares = 0;
    int         cmp_count   = 0;
    int         cycles      = 0;

    chain_if chain_if_inst();

    daisy_chain_direction_forwarder #(.IDLE_CYC(IDLE))
        daisy_chain_direction_forwarder_inst
    (
        .mclk(mclk), .rst(rst), .sleep_req(sleep_req),
        .link(chain_if_inst.dev), .awake(awake), .topology(topology)
    );

    chain_far_end #(.REPLY_CYC(REPLY)) chain_far_end_inst
    (
        .mclk(mclk), .rst(rst), .host_high_en(host_high_en),
        .host_high_bit(host_high_bit), .host_low_en(host_low_en),
        .host_low_bit(host_low_bit), .reply_arm(reply_arm),
        .reply_en(reply_en), .reply_bit(reply_bit),
        .link(chain_if_inst.far), .line_seen(line_seen),
        .replying(replying)
    );

    chain_fwd_sva #(.IDLE_CYC(IDLE)) chain_fwd_sva_inst
    (
        .mclk(mclk), .rst(rst), .dev_o(chain_if_inst.dev_o),
        .dev_oe(chain_if_inst.dev_oe), .line(chain_if_inst.line),
        .awake(awake), .topology(topology)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t: got %b want %b", $time, got, exp);
        end
    endtask : check_bit

    task check_nib(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_nib

    task give_verdict;
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Source 0 high host, 1 low host, 2 reply on both chain links, 3 a
    // high host request that the chain returns at once as its ring echo.
    // Each bit lasts 8 cycles and is compared at dst 10 cycles after it is driven.
    task send(input int src, input logic [9:0] f, input logic fwd,
              input int dst);
        logic b;
        for (int i = 0; i <= 10; i++)
        begin
            @(negedge mclk);
            b = (i < 10) ? f[i] : 1'b1;
            host_high_en = (src == 0 || src == 3) && (i < 10);
            host_high_bit = b;
            host_low_en = (src == 1) && (i < 10);
            host_low_bit = b;
            if (src >= 2)
            begin
                reply_en = (i < 10);
                reply_bit = b;
            end
            repeat (2) @(negedge mclk);
            if (i > 0)
            begin
                check_bit(chain_if_inst.line[dst], f[i-1] | !fwd);
                if (src >= 2)
                    check_bit(chain_if_inst.line[1], f[i-1]);
            end
            repeat (5) @(negedge mclk);
        end
    endtask : send

    // Waiting out the idle time first keeps the reply off a held link.
    task quiet_reply(input logic [9:0] f, input int src);
        int n;
        n = 0;
        repeat (IDLE + 12) @(negedge mclk);
        check_nib(chain_if_inst.dev_oe, 4'h0);
        reply_arm = 1'b1;
        reply_en = 1'b1;
        reply_bit = 1'b1;
        @(negedge mclk);
        reply_arm = 1'b0;
        while (!replying && n < 300)
        begin
            @(negedge mclk);
            n++;
        end
        check_bit(n >= REPLY, 1'b1);
        check_bit(replying, 1'b1);
        send(src, f, 1'b1, (src == 3) ? 3 : 0);
    endtask : quiet_reply

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        sleep_req = 1'b0;
        host_high_en = 1'b0;
        host_high_bit = 1'b1;
        host_low_en = 1'b0;
        host_low_bit = 1'b1;
        reply_arm = 1'b0;
        reply_en = 1'b0;
        reply_bit = 1'b1;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        check_bit(awake, 1'b0);
        check_nib(chain_if_inst.line, 4'hf);
        send(0, F1, 1'b1, 3);
        check_bit(awake, 1'b1);
        check_bit(topology, master_on_top);
        send(1, F2, 1'b0, 2);
        check_bit(topology, master_on_top);
        quiet_reply(F2, 2);
        quiet_reply(F1, 3);
        repeat (IDLE + 12) @(negedge mclk);
        sleep_req = 1'b1;
        repeat (4) @(negedge mclk);
        check_bit(awake, 1'b0);
        sleep_req = 1'b0;
        send(1, F2, 1'b1, 2);
        check_bit(topology, master_on_bottom);
        send(0, F1, 1'b0, 3);
        quiet_reply(F1, 2);
        give_verdict();
    end
endmodule : daisy_chain_direction_forwarder_test
